// *** logic/shsf_regs.vh ***
/*
  register offset, field positions and reset value of the host status
  register of the management-bus host controller.
  assumes: included by bare name from the design files.
*/
`ifndef SHSF_REGS_VH
`define SHSF_REGS_VH
`define SHSF_HOST_STATUS_OFS 8'h00
`define SHSF_HOST_STATUS_RST 8'h00
`define SHSF_BIT_BUSY 0
`define SHSF_BIT_DONE 1
`define SHSF_BIT_DEVERR 2
`define SHSF_BIT_COLL 3
`define SHSF_BIT_FAIL 4
`define SHSF_BIT_ALERT 5
`define SHSF_CLEAR_MASK 8'h3e
`endif

// *** logic/shsf_top.v ***
/*
  status flags (bits 5..1) and busy bit (bit 0) of the host status register of a two-wire
  management-bus host controller, with the interrupt request they raise.
  assumes: a protocol engine on the same clock gives one-cycle event pulses;
  the alert pin is asynchronous; the register port is the plain byte
  port of the controller (address, write strobe, read data).
  the alert route and the completion enable come from control logic on
  the same clock and are used as plain levels, with no synchroniser.
  the reset stands for the resume-well reset and is synchronous.
  reads are registered: the read data shows the status one cycle after
  the address is presented, as it stood the cycle before.
  writes are single-cycle strobes; a one in bits 5..1 clears that flag.
  bit 0 and bits 7..6 ignore writes.
  an event and a clear of the same flag in one cycle leave it set.
  software keeps off the controller while busy; nothing here enforces it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "shsf_regs.vh"

module shsf_top (
  input wire CLK_SYS_IN,
  input wire RST_N_IN,
  input wire [7:0] ADDR_IN,
  input wire WR_IN,
  input wire [7:0] WDATA_IN,
  output reg [7:0] RDATA_OUT,
  input wire ALERT_INPUT_PIN_N_IN,
  input wire ALERT_IS_GPIO_IN,
  input wire ALERT_ENABLE_IN,
  input wire COMPLETION_IRQ_ENABLE_IN,
  input wire CMD_START_IN,
  input wire CMD_DONE_IN,
  input wire ABORT_IN,
  input wire COLLISION_IN,
  input wire ILLEGAL_CMD_IN,
  input wire UNCLAIMED_IN,
  input wire TIMEOUT_IN,
  output reg IRQ_OUT
);

  // ***************************************************
  // flag span
  // ***************************************************
  // bits 7 and 6 of the register belong to other logic
  localparam FLAG_LO = `SHSF_BIT_DONE;
  localparam FLAG_HI = `SHSF_BIT_ALERT;

  // ***************************************************
  // decode helpers
  // ***************************************************
  // status select is shared by the write decode and the read mux
  function is_status_addr;
    input [7:0] addr;
    begin
      if (addr == `SHSF_HOST_STATUS_OFS)
        is_status_addr = 1'b1;
      else
        is_status_addr = 1'b0;
    end
  endfunction

  // every event that ends the running command, good or bad
  function is_termination;
    input done;
    input abort;
    input coll;
    input device_error_flag;
    begin
      is_termination = done | abort | coll | device_error_flag;
    end
  endfunction

  // ***************************************************
  // alert pin synchroniser and falling-edge detect
  // ***************************************************
  reg alert_s1_r;
  reg alert_s2_r;
  reg alert_s3_r;
  wire alert_fall;
  wire alert_routed;
  wire alert_assert;

  // resets to the idle high level so reset release does not fake an edge
  always @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      alert_s1_r <= 1'b1;
      alert_s2_r <= 1'b1;
      alert_s3_r <= 1'b1;
    end
    else
    begin
      alert_s1_r <= ALERT_INPUT_PIN_N_IN;
      alert_s2_r <= alert_s1_r;
      alert_s3_r <= alert_s2_r;
    end
  end

  // only the second and third stages feed logic; the first may still be settling
  assign alert_fall = alert_s3_r & ~alert_s2_r;
  // gpio use or a closed alert route keeps pin edges from setting the flag
  assign alert_routed = ~ALERT_IS_GPIO_IN & ALERT_ENABLE_IN;
  assign alert_assert = alert_fall & alert_routed;

  // ***************************************************
  // source events
  // ***************************************************
  wire device_error_flag_ev;
  wire term_ev;
  wire start_ev;
  reg busy_r;
  reg busy_nxt;
  wire [5:1] set_ev;

  assign device_error_flag_ev = ILLEGAL_CMD_IN | UNCLAIMED_IN | TIMEOUT_IN;
  assign term_ev = is_termination(CMD_DONE_IN, ABORT_IN, COLLISION_IN, device_error_flag_ev);
  assign start_ev = CMD_START_IN & ~term_ev;

  assign set_ev[`SHSF_BIT_ALERT] = alert_assert;
  // an abort with no command running has nothing to fail
  assign set_ev[`SHSF_BIT_FAIL] = ABORT_IN & busy_r;
  assign set_ev[`SHSF_BIT_COLL] = COLLISION_IN;
  assign set_ev[`SHSF_BIT_DEVERR] = device_error_flag_ev;
  // successful termination only, whatever the completion enable says
  assign set_ev[`SHSF_BIT_DONE] = CMD_DONE_IN;

  // ***************************************************
  // write-one-to-clear decode
  // ***************************************************
  wire sts_wr;
  reg [7:0] clr;

  assign sts_wr = WR_IN & is_status_addr(ADDR_IN);

  // zero bits in the write data clear nothing; busy is read-only
  always @*
  begin
    clr = 8'h00;
    if (sts_wr)
    begin
      clr = WDATA_IN & `SHSF_CLEAR_MASK;
    end
  end

  // ***************************************************
  // busy indicator
  // ***************************************************
  // a terminating event in the start cycle wins, so busy never sticks
  always @*
  begin
    busy_nxt = busy_r;
    if (term_ev)
    begin
      busy_nxt = 1'b0;
    end
    else if (start_ev)
    begin
      busy_nxt = 1'b1;
    end
  end

  always @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      busy_r <= 1'b0;
    end
    else
    begin
      busy_r <= busy_nxt;
    end
  end

  // ***************************************************
  // sticky flags: a set in the clearing cycle wins
  // ***************************************************
  wire [5:1] flag_vec;
  genvar gi;

  generate
    for (gi = FLAG_LO; gi <= FLAG_HI; gi = gi + 1)
    begin : g_flag
      reg bit_r;
      reg bit_nxt;

      // alert clears only by write-one here or by reset below
      always @*
      begin
        if (set_ev[gi])
        begin
          bit_nxt = 1'b1;
        end
        else if (clr[gi])
        begin
          bit_nxt = 1'b0;
        end
        else
        begin
          bit_nxt = bit_r;
        end
      end

      always @(posedge CLK_SYS_IN)
      begin
        if (!RST_N_IN)
        begin
          bit_r <= 1'b0;
        end
        else
        begin
          bit_r <= bit_nxt;
        end
      end

      assign flag_vec[gi] = bit_r;
    end
  endgenerate

  // ***************************************************
  // interrupt request
  // ***************************************************
  wire [5:1] irq_src;
  reg irq_nxt;

  // done only reaches the request when the completion enable is set
  assign irq_src[`SHSF_BIT_DONE] = flag_vec[`SHSF_BIT_DONE] & COMPLETION_IRQ_ENABLE_IN;
  assign irq_src[`SHSF_BIT_DEVERR] = flag_vec[`SHSF_BIT_DEVERR];
  assign irq_src[`SHSF_BIT_COLL] = flag_vec[`SHSF_BIT_COLL];
  assign irq_src[`SHSF_BIT_FAIL] = flag_vec[`SHSF_BIT_FAIL];
  assign irq_src[`SHSF_BIT_ALERT] = flag_vec[`SHSF_BIT_ALERT];

  // follows the flags a cycle later, so a clear drops it after the flag
  always @*
  begin
    irq_nxt = 1'b0;
    if (irq_src != 5'h00)
    begin
      irq_nxt = 1'b1;
    end
  end

  always @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      IRQ_OUT <= 1'b0;
    end
    else
    begin
      IRQ_OUT <= irq_nxt;
    end
  end

  // ***************************************************
  // read data
  // ***************************************************
  wire [7:0] status_word;
  reg [7:0] rdata_nxt;

  // the two top bits belong to other logic and read as zero here
  assign status_word = {2'b00, flag_vec, busy_r};

  always @*
  begin
    if (is_status_addr(ADDR_IN))
    begin
      rdata_nxt = status_word;
    end
    else
    begin
      rdata_nxt = 8'h00;
    end
  end

  always @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      RDATA_OUT <= `SHSF_HOST_STATUS_RST;
    end
    else
    begin
      RDATA_OUT <= rdata_nxt;
    end
  end

endmodule // shsf_top
`default_nettype wire

// *** test/shsf_checker.sv ***
/* checker: status flag timing seen at the top ports
   assumes: bound into shsf_top, status register at 8'h00 */
`timescale 1ns/10ps
`default_nettype none
module shsf_checker (
  input wire logic CLK_SYS_IN, RST_N_IN, WR_IN, CMD_DONE_IN, COLLISION_IN,
  input wire logic ALERT_INPUT_PIN_N_IN, ALERT_IS_GPIO_IN, ALERT_ENABLE_IN, IRQ_OUT,
  input wire logic [7:0] ADDR_IN, WDATA_IN, RDATA_OUT
);
  // ****
  // address history, reads elsewhere blank the read data
  // ****
  wire z = ADDR_IN == 8'h00;
  wire clr5 = WR_IN && z && WDATA_IN[5];
  wire clr1 = WR_IN && z && WDATA_IN[1];
  logic z_r;
  always_ff @(posedge CLK_SYS_IN) z_r <= z;
  wire zz = z && z_r;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  a_done_ends_busy: assert property (CMD_DONE_IN ##1 z |-> ##1 RDATA_OUT[1:0] == 2'h2)
    else $error("done flag or busy wrong");
  a_coll_sets: assert property (COLLISION_IN ##1 z |-> ##1 RDATA_OUT[3])
    else $error("collision flag not set");
  a_alert_sets: assert property ($fell(ALERT_INPUT_PIN_N_IN) && !ALERT_IS_GPIO_IN
    && ALERT_ENABLE_IN |-> ##[3:5] RDATA_OUT[5])
    else $error("alert flag not set");
  a_gpio_no_alert: assert property ($rose(RDATA_OUT[5]) && $past(zz) |-> !$past(ALERT_IS_GPIO_IN, 2))
    else $error("alert flag set in gpio mode");
  a_alert_clear: assert property ($fell(RDATA_OUT[5]) && $past(zz) |-> $past(clr5, 2))
    else $error("alert flag cleared without write");
  a_done_clear: assert property ($fell(RDATA_OUT[1]) && $past(zz) |-> $past(clr1, 2))
    else $error("done flag cleared without write");
  a_irq_idle: assert property ($past(z) && RDATA_OUT[5:1] == 5'h00 |-> !IRQ_OUT)
    else $error("irq high with no flag");
  a_irq_coll: assert property ($past(z) && RDATA_OUT[3] |-> IRQ_OUT)
    else $error("irq low with collision flag");
  cover property (CMD_DONE_IN);
  cover property ($rose(RDATA_OUT[5]));
  cover property (COLLISION_IN ##2 IRQ_OUT);
endmodule // shsf_checker
bind shsf_top shsf_checker shsf_checker_inst (.*);
`default_nettype wire

// *** test/shsf_tb_top.sv ***
/* bench: steps of event, write and status read through the ports
   assumes: status at 8'h00, checker bound on its own */
`timescale 1ns/10ps
`default_nettype none
module shsf_tb_top;
  logic CLK_SYS_IN = 1'h0, RST_N_IN = 1'h0, WR_IN = 1'h0;
  logic [7:0] ADDR_IN = 8'h00, WDATA_IN = 8'h00;
  logic [6:0] ev = 7'h00;
  logic [3:0] ctl = 4'h8;
  wire IRQ_OUT, CMD_START_IN, CMD_DONE_IN, ABORT_IN, COLLISION_IN, ILLEGAL_CMD_IN;
  wire UNCLAIMED_IN, TIMEOUT_IN, ALERT_ENABLE_IN, ALERT_IS_GPIO_IN, COMPLETION_IRQ_ENABLE_IN;
  wire ALERT_INPUT_PIN_N_IN = !ctl[0];
  wire [7:0] RDATA_OUT;
  int bad_count = 0, checks = 0;
  assign {TIMEOUT_IN, UNCLAIMED_IN, ILLEGAL_CMD_IN, COLLISION_IN} = ev[6:3];
  assign {ABORT_IN, CMD_DONE_IN, CMD_START_IN} = ev[2:0];
  assign {ALERT_ENABLE_IN, ALERT_IS_GPIO_IN, COMPLETION_IRQ_ENABLE_IN} = ctl[3:1];
  shsf_top shsf_top_inst (.*);
  initial forever #5 CLK_SYS_IN = ~CLK_SYS_IN;
  task chk(input logic [8:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected irq_status exp %h seen %h", exp, seen);
    end
  endtask
  // ****
  // step word: ctl, event, write data, unmapped and irq, status
  // ****
  task step(input logic [31:0] s);
    @(posedge CLK_SYS_IN);
    {ctl, ev} <= {s[31:28], s[26:20]};
    @(posedge CLK_SYS_IN);
    {ev, WR_IN, ADDR_IN, WDATA_IN} <= {7'h00, |s[19:11], 7'h00, s[11], s[19:12]};
    @(posedge CLK_SYS_IN);
    {WR_IN, ADDR_IN} <= 9'h000;
    repeat (4) @(posedge CLK_SYS_IN);
    #1 chk({IRQ_OUT, RDATA_OUT}, s[8:0]);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge CLK_SYS_IN);
    RST_N_IN <= 1'h1;
    step(32'h8000_0000);
    step(32'h8010_0001);
    step(32'h8020_0002);
    step(32'ha000_0102);
    step(32'ha00f_f902);
    step(32'ha000_2000);
    step(32'ha010_0001);
    step(32'ha040_0110);
    step(32'ha080_0118);
    for (int i = 0; i < 3; i++)
    begin
      step({4'ha, 8'h10 << i, 20'h0011c});
      step(32'ha000_4118);
    end
    step(32'ha001_8000);
    step(32'hb000_0120);
    step(32'ha00d_f120);
    step(32'ha002_0000);
    step(32'hf000_0000);
    end_sim;
  end
  initial
  begin
    repeat (500) @(posedge CLK_SYS_IN);
    bad_count++;
    end_sim;
  end
endmodule // shsf_tb_top
`default_nettype wire
